//--- logic/tpg_pkg.sv
`default_nettype none

package tpg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W  = 12;
  localparam int CMP_W  = 13;
  localparam int REP_W  = 8;
  localparam int PSC_W  = 3;
  localparam int PH_N   = 3;
  localparam int SLOT_N = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Compare slots 0..2 are phases a..c, slot 3 is the period
  localparam int PER_SLOT = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_REP      = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CMP_BASE = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CMP_LAST = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_FLAG     = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_IEN      = 4'hb;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_PSC_LSB   = 0;
  localparam int CTRL_ALIGN_BIT = 3;
  localparam int CTRL_BYTE_BIT  = 4;
  localparam int CTRL_OVF_LSB   = 5;
  localparam int FLAG_UPD_BIT   = 7;
  localparam int IEN_UPD_BIT    = 7;
  localparam int IEN_CKE_BIT    = 0;
  localparam int HI_BYTE_BIT    = 0;
  localparam int ROUND_LSB      = 3;
  localparam int HALF_BIT       = 2;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RESYNC_CODE = 8'hff;
  localparam logic [DATA_W-1:0] CTRL_RST    = 8'h00;
  localparam logic [DATA_W-1:0] REP_RST     = 8'h00;
  localparam logic [DATA_W-1:0] IEN_RST     = 8'h00;
  localparam logic [DATA_W-1:0] CMP_LO_RST  = 8'h00;
  localparam logic [DATA_W-1:0] CMP_HI_RST  = 8'h00;
  localparam logic [DATA_W-1:0] PER_LO_RST  = 8'hff;
  localparam logic [DATA_W-1:0] PER_HI_RST  = 8'h0f;
  localparam logic [DATA_W-1:0] RD_NONE     = 8'h00;
  localparam logic [CMP_W-1:0]  CMP_MAX     = 13'h1fff;

  typedef enum logic {TPG_UP, TPG_DOWN} tpg_dir_t;

  // Left-aligned 16-bit word rounded to 13 bits, saturating at the top
  function automatic logic [CMP_W-1:0] tpg_round(input logic [15:0] word);
    logic [CMP_W:0] sum;
    sum = {1'b0, word[15:ROUND_LSB]} + {{CMP_W{1'b0}}, word[HALF_BIT]};
    return sum[CMP_W] ? CMP_MAX : sum[CMP_W-1:0];
  endfunction : tpg_round

endpackage : tpg_pkg

`default_nettype wire

//--- logic/tpg_prescaler.sv
`default_nettype none

module tpg_prescaler
  import tpg_pkg::*;
#(
  parameter int W = PSC_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic [W-1:0] div,
  output logic              tick
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_reg;
  logic         tick_next;

  // Divides by div+1: one tick every div+1 clocks
  always_comb begin
    cnt_next  = cnt_reg + 1'b1;
    tick_next = 1'b0;
    if (clear) begin
      cnt_next = '0;
    end else if (cnt_reg >= div) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : tpg_prescaler

`default_nettype wire

//--- logic/tpg_pwm.sv
// Summary of operation
// - Three phase outputs from one 12-bit counter against three 13-bit compares.
// - A 12-bit period compare sets the carrier period and the turning point.
// - All compares are preloaded; active copies change at update events or at a deferred transfer.
// - Counter clock comes from a 3-bit prescaler dividing by 1 to 8.
// - Prescaler setting is preloaded and takes effect at the next update.
// - Center mode counts up to the period, down to zero, and repeats.
// - Center mode: output low on up-count match, high on down-count match.
// - Edge mode wraps to zero after the period; low on match, high at clear.
// - Compare above extended period holds high; compare zero holds low.
// - Comparisons use the counter zero-extended to 13 bits.
// - An update between low and high writes is deferred until the high write.
// - Byte mode uses 8-bit compares; full-duty bits force 100% and clear on update.
// - Reads of preloaded registers return the preload contents.
// - Phase compares are left-aligned 16-bit words rounded to 13 bits on load.
// - Transfers happen at wrap events only when the repetition counter is zero.
// - Repetition counts wraps: one per period in edge, two in center mode.
// - Repetition counter reloads itself from the repetition register at zero.
// - The update flag is raised together with every update event.
// - Writing ff to the flag register resets the counter and forces an update.
// - Counter held at zero while disabled; enabling forces an update.
//
// Local design decisions: strobed register access and the address map.
`default_nettype none

module tpg_pwm
  import tpg_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   phase_a_pwm,
  output logic                   phase_b_pwm,
  output logic                   phase_c_pwm,
  output logic                   update_pulse,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic is_cmp(input logic [ADDR_W-1:0] a);
    return (a >= OFS_CMP_BASE) && (a <= OFS_CMP_LAST);
  endfunction : is_cmp

  function automatic logic [1:0] slot_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = a - OFS_CMP_BASE;
    return rel[2:1];
  endfunction : slot_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_pre_reg, ctrl_pre_next;
  logic [DATA_W-1:0] rep_pre_reg, rep_pre_next;
  logic [DATA_W-1:0] ien_reg, ien_next;
  logic [REP_W-1:0]  rep_cnt_reg, rep_cnt_next;
  logic [PSC_W-1:0]  psc_act_reg, psc_act_next;
  logic              align_act_reg, align_act_next;
  logic [DATA_W-1:0] lo_reg [SLOT_N];
  logic [DATA_W-1:0] lo_next [SLOT_N];
  logic [DATA_W-1:0] hi_reg [SLOT_N];
  logic [DATA_W-1:0] hi_next [SLOT_N];
  logic [SLOT_N-1:0] pend_reg, pend_next;
  logic [SLOT_N-1:0] defer_reg, defer_next;
  logic [CNT_W-1:0]  per_act_reg, per_act_next;
  logic [CMP_W-1:0]  ph_act_reg [PH_N];
  logic [CMP_W-1:0]  ph_act_next [PH_N];
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  tpg_dir_t          dir_reg, dir_next;
  logic              flag_reg, flag_next;
  logic              cke_d_reg;
  logic              upd_pulse_reg;
  logic              irq_reg, irq_next;
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;
  logic [PH_N-1:0]   pwm_q;

  logic              tick;
  logic              cke;
  logic              byte_pre;
  logic              resync;
  logic              cke_rise;
  logic              wrap;
  logic              upd;
  logic [SLOT_N-1:0] load_v;

  assign cke      = ien_reg[IEN_CKE_BIT];
  assign byte_pre = ctrl_pre_reg[CTRL_BYTE_BIT];
  assign resync   = wr_stb && (addr == OFS_FLAG) && (wr_data == RESYNC_CODE);
  assign cke_rise = cke && !cke_d_reg;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Cleared on resync so the new period starts with a full prescale step
  tpg_prescaler #(
    .W (PSC_W)
  ) u_psc (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (resync || !cke),
    .div      (psc_act_reg),
    .tick     (tick)
  );

  // ----------------------------------------------------------------
  // Counter, update and registers
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next       = cnt_reg;
    dir_next       = dir_reg;
    wrap           = 1'b0;
    ctrl_pre_next  = ctrl_pre_reg;
    rep_pre_next   = rep_pre_reg;
    ien_next       = ien_reg;
    rep_cnt_next   = rep_cnt_reg;
    psc_act_next   = psc_act_reg;
    align_act_next = align_act_reg;
    lo_next        = lo_reg;
    hi_next        = hi_reg;
    pend_next      = pend_reg;
    defer_next     = defer_reg;
    per_act_next   = per_act_reg;
    ph_act_next    = ph_act_reg;
    load_v         = '0;
    rd_data_next   = RD_NONE;

    if (!cke || resync) begin
      cnt_next = '0;
      dir_next = TPG_UP;
    end else if (tick) begin
      if (align_act_reg) begin
        if (dir_reg == TPG_UP) begin
          if (cnt_reg >= per_act_reg) begin
            wrap     = 1'b1;
            dir_next = TPG_DOWN;
            cnt_next = cnt_reg - 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end else if (cnt_reg == '0) begin
          wrap     = 1'b1;
          dir_next = TPG_UP;
          cnt_next = cnt_reg + 1'b1;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end else if (cnt_reg >= per_act_reg) begin
        wrap     = 1'b1;
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end

    // Forced updates (resync, enable) bypass the repetition gate
    upd = (wrap && (rep_cnt_reg == '0)) || resync || cke_rise;

    if (resync || cke_rise) begin
      rep_cnt_next = rep_pre_reg;
    end else if (wrap) begin
      rep_cnt_next = (rep_cnt_reg == '0) ? rep_pre_reg : rep_cnt_reg - 1'b1;
    end

    if (upd) begin
      psc_act_next   = ctrl_pre_reg[CTRL_PSC_LSB +: PSC_W];
      align_act_next = ctrl_pre_reg[CTRL_ALIGN_BIT];
      ctrl_pre_next[CTRL_OVF_LSB +: PH_N] = '0;
    end

    if (wr_stb && (addr == OFS_CTRL)) begin
      ctrl_pre_next = wr_data;
    end
    if (wr_stb && (addr == OFS_REP)) begin
      rep_pre_next = wr_data;
    end
    if (wr_stb && (addr == OFS_IEN)) begin
      ien_next = wr_data;
    end

    for (int s = 0; s < SLOT_N; s++) begin
      if (wr_stb && is_cmp(addr) && (slot_of(addr) == 2'(s))) begin
        if (addr[HI_BYTE_BIT]) begin
          hi_next[s]   = wr_data;
          pend_next[s] = 1'b0;
        end else begin
          lo_next[s]   = wr_data;
          pend_next[s] = !byte_pre;
        end
      end
      if (upd) begin
        if (pend_reg[s] && !byte_pre) begin
          defer_next[s] = 1'b1;
        end else begin
          load_v[s] = 1'b1;
        end
      end
      // Deferred transfer runs the cycle after the high byte lands
      if (defer_reg[s] && !pend_reg[s]) begin
        load_v[s]     = 1'b1;
        defer_next[s] = 1'b0;
      end
    end

    if (load_v[PER_SLOT]) begin
      per_act_next = byte_pre ? {4'h0, hi_reg[PER_SLOT]}
                              : {hi_reg[PER_SLOT][3:0], lo_reg[PER_SLOT]};
    end
    for (int p = 0; p < PH_N; p++) begin
      if (load_v[p]) begin
        ph_act_next[p] = byte_pre ? {4'h0, ctrl_pre_reg[CTRL_OVF_LSB + p], hi_reg[p]}
                                  : tpg_round({hi_reg[p], lo_reg[p]});
      end
    end

    // Set wins over a clear in the same cycle
    flag_next = flag_reg;
    if (wr_stb && (addr == OFS_FLAG) && !wr_data[FLAG_UPD_BIT]) begin
      flag_next = 1'b0;
    end
    if (upd) begin
      flag_next = 1'b1;
    end
    irq_next = flag_reg && ien_reg[IEN_UPD_BIT];

    if (rd_stb) begin
      if (is_cmp(addr)) begin
        rd_data_next = addr[HI_BYTE_BIT] ? hi_reg[slot_of(addr)] : lo_reg[slot_of(addr)];
      end else begin
        unique case (addr)
          OFS_CTRL: rd_data_next = ctrl_pre_reg;
          OFS_REP:  rd_data_next = rep_pre_reg;
          OFS_FLAG: rd_data_next = {flag_reg, 7'h00};
          OFS_IEN:  rd_data_next = ien_reg;
          default:  rd_data_next = RD_NONE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg       <= '0;
      dir_reg       <= TPG_UP;
      ctrl_pre_reg  <= CTRL_RST;
      rep_pre_reg   <= REP_RST;
      ien_reg       <= IEN_RST;
      rep_cnt_reg   <= '0;
      psc_act_reg   <= CTRL_RST[CTRL_PSC_LSB +: PSC_W];
      align_act_reg <= CTRL_RST[CTRL_ALIGN_BIT];
      for (int s = 0; s < SLOT_N; s++) begin
        lo_reg[s] <= (s == PER_SLOT) ? PER_LO_RST : CMP_LO_RST;
        hi_reg[s] <= (s == PER_SLOT) ? PER_HI_RST : CMP_HI_RST;
      end
      pend_reg      <= '0;
      defer_reg     <= '0;
      per_act_reg   <= {PER_HI_RST[3:0], PER_LO_RST};
      for (int p = 0; p < PH_N; p++) begin
        ph_act_reg[p] <= '0;
      end
      flag_reg      <= 1'b0;
      cke_d_reg     <= 1'b0;
      upd_pulse_reg <= 1'b0;
      irq_reg       <= 1'b0;
      rd_data_reg   <= RD_NONE;
    end else begin
      cnt_reg       <= cnt_next;
      dir_reg       <= dir_next;
      ctrl_pre_reg  <= ctrl_pre_next;
      rep_pre_reg   <= rep_pre_next;
      ien_reg       <= ien_next;
      rep_cnt_reg   <= rep_cnt_next;
      psc_act_reg   <= psc_act_next;
      align_act_reg <= align_act_next;
      lo_reg        <= lo_next;
      hi_reg        <= hi_next;
      pend_reg      <= pend_next;
      defer_reg     <= defer_next;
      per_act_reg   <= per_act_next;
      ph_act_reg    <= ph_act_next;
      flag_reg      <= flag_next;
      cke_d_reg     <= cke;
      upd_pulse_reg <= upd;
      irq_reg       <= irq_next;
      rd_data_reg   <= rd_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Phase outputs
  // ----------------------------------------------------------------
  for (genvar g = 0; g < PH_N; g++) begin : g_phase
    logic lvl_reg;
    logic lvl_next;

    // Level-based match is safe: the counter dwells on a value for a whole prescale step
    always_comb begin
      lvl_next = lvl_reg;
      if (ph_act_reg[g] == '0) begin
        lvl_next = 1'b0;
      end else if (ph_act_reg[g] > {1'b0, per_act_reg}) begin
        lvl_next = 1'b1;
      end else if ({1'b0, cnt_reg} == ph_act_reg[g]) begin
        lvl_next = align_act_reg && (dir_reg == TPG_DOWN);
      end else if (!align_act_reg && (cnt_reg == '0)) begin
        lvl_next = 1'b1;
      end
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        lvl_reg <= 1'b0;
      end else begin
        lvl_reg <= lvl_next;
      end
    end

    assign pwm_q[g] = lvl_reg;
  end

  assign phase_a_pwm  = pwm_q[0];
  assign phase_b_pwm  = pwm_q[1];
  assign phase_c_pwm  = pwm_q[2];
  assign update_pulse = upd_pulse_reg;
  assign irq          = irq_reg;
  assign rd_data      = rd_data_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_resync_wr;
    wr_stb && (addr == OFS_FLAG) && (wr_data == RESYNC_CODE);
  endsequence

  sequence s_upd_done;
    upd_pulse_reg && flag_reg;
  endsequence

  property p_resync;
    s_resync_wr |=> (cnt_reg == '0) ##0 s_upd_done;
  endproperty
  a_resync: assert property (p_resync) else $error("resync did not clear counter and update");

  property p_idle;
    !cke |=> (cnt_reg == '0) && (dir_reg == TPG_UP);
  endproperty
  a_idle: assert property (p_idle) else $error("counter moved while disabled");

  property p_cke_start;
    $rose(cke) |=> s_upd_done;
  endproperty
  a_cke_start: assert property (p_cke_start) else $error("enable did not force an update");

  property p_edge_wrap;
    cke && tick && !resync && !align_act_reg && (cnt_reg >= per_act_reg) |=> cnt_reg == '0;
  endproperty
  a_edge_wrap: assert property (p_edge_wrap) else $error("edge mode did not wrap at period");

  property p_center_turn;
    cke && tick && !resync && align_act_reg && (dir_reg == TPG_UP) && (cnt_reg >= per_act_reg)
      |=> (dir_reg == TPG_DOWN) && (cnt_reg == $past(cnt_reg) - 1'b1);
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("center mode did not turn down");

  property p_rep_gate;
    wrap && (rep_cnt_reg != '0) && !resync && !cke_rise |=> !upd_pulse_reg;
  endproperty
  a_rep_gate: assert property (p_rep_gate) else $error("update without repetition zero");

  property p_psc_hold;
    $changed(psc_act_reg) |-> upd_pulse_reg;
  endproperty
  a_psc_hold: assert property (p_psc_hold) else $error("prescaler changed outside update");

  property p_irq;
    flag_reg && ien_reg[IEN_UPD_BIT] |=> irq_reg;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_zero_low;
    ph_act_reg[0] == '0 |=> !phase_a_pwm;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero compare not held low");

  property p_full_high;
    ph_act_reg[1] > {1'b0, per_act_reg} |=> phase_b_pwm;
  endproperty
  a_full_high: assert property (p_full_high) else $error("full compare not held high");

  property p_defer;
    upd && pend_reg[0] && !byte_pre |=> defer_reg[0] && (ph_act_reg[0] == $past(ph_act_reg[0]));
  endproperty
  a_defer: assert property (p_defer) else $error("transfer not deferred");

  property p_ovf_clear;
    upd && !(wr_stb && (addr == OFS_CTRL)) |=> ctrl_pre_reg[CTRL_OVF_LSB +: PH_N] == '0;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("full-duty bits not cleared");

  property p_rd_pre;
    rd_stb && (addr == OFS_REP) |=> rd_data == $past(rep_pre_reg);
  endproperty
  a_rd_pre: assert property (p_rd_pre) else $error("read did not return preload");

endmodule : tpg_pwm

`default_nettype wire

//--- testbench/tb_three_phase_pwm_generator.sv
`default_nettype none

module tb_three_phase_pwm_generator
  import tpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              core_clk = 1'b0;
  logic              rst      = 1'b1;
  logic [ADDR_W-1:0] addr     = '0;
  logic [DATA_W-1:0] wr_data  = '0;
  logic              wr_stb   = 1'b0;
  logic              rd_stb   = 1'b0;
  logic              clr      = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic [2:0]        pwm;
  logic              update_pulse;
  logic              irq;
  logic [15:0]       hi_a, hi_b, hi_c, n_upd;
  int                mismatches = 0;
  int                n_checks   = 0;
  int                cycles     = 0;

  always #10 core_clk = ~core_clk;

  tpg_pwm dut (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .phase_a_pwm(pwm[0]), .phase_b_pwm(pwm[1]), .phase_c_pwm(pwm[2]),
    .update_pulse(update_pulse), .irq(irq)
  );

  tpg_phase_sink sink (
    .core_clk(core_clk), .clear(clr), .pwm(pwm), .upd(update_pulse),
    .hi_a(hi_a), .hi_b(hi_b), .hi_c(hi_c), .n_upd(n_upd)
  );

  // --------------------------------------------------
  // Shared tasks
  // --------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge core_clk);
    wr_stb  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rd_data});
  endtask : rd

  task automatic irq_is(input int n, input logic e);
    repeat (n) @(posedge core_clk);
    #1;
    chk("irq", {15'h0, e}, {15'h0, irq});
  endtask : irq_is

  // Whole carrier periods in the window make the counts phase-independent
  task automatic meas(input int settle, input int n, input logic [15:0] ea, eb, ec, eu);
    repeat (settle) @(posedge core_clk);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
    chk("high a", ea, hi_a);
    chk("high b", eb, hi_b);
    chk("high c", ec, hi_c);
    chk("updates", eu, n_upd);
  endtask : meas

  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic t_reset;
    irq_is(0, 1'b0);
    rd(OFS_CTRL, CTRL_RST);
    rd(4'h8, PER_LO_RST);
    rd(4'h9, PER_HI_RST);
    rd(4'hc, RD_NONE);
    meas(0, 20, 0, 0, 0, 0);
  endtask : t_reset

  task automatic t_edge;
    wr(4'h8, 8'h08);
    wr(4'h9, 8'h00);
    wr(4'h2, 8'h20);
    wr(4'h3, 8'h00);
    wr(4'h6, 8'h48);
    wr(4'h7, 8'h00);
    wr(4'h4, 8'hff);
    wr(4'h5, 8'hff);
    rd(4'h2, 8'h20);
    wr(OFS_IEN, 8'h81);
    irq_is(4, 1'b1);
    meas(20, 90, 40, 90, 90, 10);
    rd(OFS_FLAG, 8'h80);
    wr(OFS_IEN, 8'h01);
    irq_is(3, 1'b0);
  endtask : t_edge

  task automatic t_defer;
    wr(4'h2, 8'h2c);
    meas(20, 90, 40, 90, 90, 10);
    wr(4'h3, 8'h00);
    meas(20, 90, 60, 90, 90, 10);
  endtask : t_defer

  task automatic t_presc;
    wr(OFS_CTRL, 8'h01);
    meas(40, 180, 120, 180, 180, 10);
  endtask : t_presc

  task automatic t_rep;
    wr(OFS_CTRL, 8'h00);
    wr(OFS_REP, 8'h02);
    rd(OFS_REP, 8'h02);
    meas(60, 270, 180, 270, 270, 10);
  endtask : t_rep

  task automatic t_center;
    wr(OFS_REP, 8'h01);
    wr(OFS_CTRL, 8'h08);
    wr(OFS_FLAG, RESYNC_CODE);
    rd(OFS_FLAG, 8'h80);
    wr(OFS_FLAG, 8'h7f);
    rd(OFS_FLAG, 8'h00);
    meas(40, 160, 120, 160, 160, 10);
  endtask : t_center

  // Long repetition keeps the full-duty value active through the window
  task automatic t_byte;
    wr(OFS_CTRL, 8'h30);
    wr(OFS_REP, 8'h07);
    wr(4'h3, 8'h04);
    wr(4'h9, 8'h08);
    wr(OFS_FLAG, RESYNC_CODE);
    meas(0, 45, 45, 45, 0, 0);
    wr(OFS_REP, 8'h00);
    meas(160, 90, 40, 90, 0, 10);
    rd(OFS_CTRL, 8'h10);
  endtask : t_byte

  // --------------------------------------------------
  // Sequence and watchdog
  // --------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_edge();
    t_defer();
    t_presc();
    t_rep();
    t_center();
    t_byte();
    close_out();
  end
endmodule : tb_three_phase_pwm_generator

`default_nettype wire

//--- testbench/tpg_phase_sink.sv
`default_nettype none

// --------------------------------------------------
// Channel-side load
// --------------------------------------------------
module tpg_phase_sink (
  input  wire logic        core_clk,
  input  wire logic        clear,
  input  wire logic [2:0]  pwm,
  input  wire logic        upd,
  output logic      [15:0] hi_a,
  output logic      [15:0] hi_b,
  output logic      [15:0] hi_c,
  output logic      [15:0] n_upd
);
  timeunit 1ns;
  timeprecision 1ns;

  // Counts high cycles per phase, as the dead-time stage sees them.
  // Purely passive, so it cannot hide a fault of the block.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      hi_a  <= 16'h0000;
      hi_b  <= 16'h0000;
      hi_c  <= 16'h0000;
      n_upd <= 16'h0000;
    end else begin
      hi_a  <= hi_a + 16'(pwm[0]);
      hi_b  <= hi_b + 16'(pwm[1]);
      hi_c  <= hi_c + 16'(pwm[2]);
      n_upd <= n_upd + 16'(upd);
    end
  end
endmodule : tpg_phase_sink

`default_nettype wire
